// >>> hmcp_regs.svh
/*
  Constants of the monitor command port: slave address, command bit
  positions, reset values and field widths.
  Assumes inclusion by the port module.
*/
`ifndef HMCP_REGS_SVH
`define HMCP_REGS_SVH

`define HMCP_ADDR_BASE     5'h16
`define HMCP_CMD_RESET     8'h00
`define HMCP_CMD_VOLTAGE_CONTINUOUS    0
`define HMCP_CMD_V_ONCE    1
`define HMCP_CMD_CURRENT_CONTINUOUS    2
`define HMCP_CMD_I_ONCE    3
`define HMCP_CMD_DIV_SEL   4
`define HMCP_CMD_UNUSED    5
`define HMCP_CMD_STAT_SEL  6
`define HMCP_CMD_EXT       7
`define HMCP_ADC_W         12
`define HMCP_BYTE_BITS     4'h8
`define HMCP_STRAP_WAIT    2'h3
`define HMCP_RESULT_RESET  12'h000

`endif

// >>> hmcp_pkg.sv
/*
  Types of the monitor command port: bus state and converter channel.
  Assumes nothing beyond the constants header.
*/
`default_nettype none

package hmcp_pkg;

  typedef enum logic [2:0] {
    HMCP_IDLE      = 3'h0,
    HMCP_ADDR      = 3'h1,
    HMCP_ADDR_ACK  = 3'h3,
    HMCP_WRITE     = 3'h2,
    HMCP_WRITE_ACK = 3'h6,
    HMCP_READ      = 3'h7,
    HMCP_READ_ACK  = 3'h5,
    HMCP_IGNORE    = 3'h4
  } hmcp_state_t;

  typedef enum logic {
    HMCP_CHAN_VOLT = 1'b0,
    HMCP_CHAN_CURR = 1'b1
  } hmcp_chan_t;

endpackage : hmcp_pkg

`default_nettype wire

// >>> hmcp_i2c_port.sv
/*
  Two-wire slave command port of a power monitor: address match with
  strap bits, command byte, extended register write, conversion
  scheduling and two or three byte readback.
  Assumes SCL and SDA arrive asynchronously and are oversampled by
  ref_clk; the converter handshake and status byte are on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hmcp_regs.svh"

// Notes on behaviour
// - SDA falling while SCL high starts transfer
// - First byte: 7-bit address MSB first, direction
// - Matching address acknowledged low through ninth pulse
// - Mismatch leaves SDA released until stop
// - Eight data bits then one acknowledge bit
// - SDA changes only while SCL low; stop
// - First written byte is the command byte
// - Read ends with master NACK then stop
// - Address 10110 plus two strap bits
// - Quick command: address, acknowledge, stop only
// - MSB zero command, one extended; both acked
// - Seven command bits reset zero, bit five unused
// - Bit zero: continuous voltage, early read zeros
// - Bit one: single voltage, NACK reads meanwhile
// - Bit two: continuous current, early read zeros
// - Bit three: single current, NACK reads meanwhile
// - Bit four picks 14:1 or 7:2 divider
// - Bit six returns status byte on reads
// - Both quantities: three byte packed readback
// - One quantity: two bytes, low nibble zero
// - Twelve bit results via input multiplexer
module hmcp_i2c_port
  import hmcp_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  input  wire logic                    sclIn,
  input  wire logic                    sdaIn,
  output logic                         sdaOut,
  output logic                         sdaOe,
  input  wire logic [1:0]              addrStrap,
  output logic                         convStart,
  output hmcp_chan_t                   convChannel,
  input  wire logic                    convDone,
  input  wire logic [`HMCP_ADC_W-1:0]  convData,
  output logic                         dividerSelect,
  input  wire logic [7:0]              statusIn,
  output logic [1:0]                   extRegAddr,
  output logic [7:0]                   extRegData,
  output logic                         extRegWrite
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic                    sclQ1, sclQ2, sclQ3;
  logic                    sdaQ1, sdaQ2, sdaQ3;
  logic [1:0]              strapQ1, strapQ2;
  logic [1:0]              strapWait;
  logic [1:0]              strap;
  hmcp_state_t             state;
  logic [3:0]              bitCnt;
  logic [7:0]              rxShift;
  logic [7:0]              txShift, firstByte, followByte;
  logic [1:0]              byteIdx;
  logic                    extPending;
  logic [7:0]              cmd;
  logic                    voltSel, currSel;
  logic                    adcBusy;
  hmcp_chan_t              lastChan;
  logic [`HMCP_ADC_W-1:0]  voltResult, currResult;
  logic                    sclRise, sclFall, startSeen, stopSeen;
  logic                    byteEnd, addrMatch, onceBusy;
  logic                    cmdWrite, extAddrWrite, extDataWrite;
  logic                    voltReq, currReq, convStore;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {sclQ1, sclQ2, sclQ3} <= 3'h7;
      {sdaQ1, sdaQ2, sdaQ3} <= 3'h7;
      {strapQ1, strapQ2}    <= 4'h0;
    end else begin
      {sclQ3, sclQ2, sclQ1} <= {sclQ2, sclQ1, sclIn};
      {sdaQ3, sdaQ2, sdaQ1} <= {sdaQ2, sdaQ1, sdaIn};
      {strapQ2, strapQ1}    <= {strapQ1, addrStrap};
    end
  end

  // Strap sampled over three cycles after reset release, then held
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      strapWait <= 2'h0;
      strap     <= 2'h0;
    end else if (strapWait != `HMCP_STRAP_WAIT) begin
      strapWait <= strapWait + 2'h1;
      strap     <= strapQ2;
    end
  end

  // ---------------------------------------------------------------
  // Bus events
  // ---------------------------------------------------------------
  assign sclRise   = sclQ2 && !sclQ3;
  assign sclFall   = !sclQ2 && sclQ3;
  assign startSeen = sclQ2 && sclQ3 && !sdaQ2 && sdaQ3;
  assign stopSeen  = sclQ2 && sclQ3 && sdaQ2 && !sdaQ3;
  assign byteEnd   = sclFall && (bitCnt == `HMCP_BYTE_BITS);
  assign addrMatch = (rxShift[7:1] == {`HMCP_ADDR_BASE, strap});
  assign onceBusy  = cmd[`HMCP_CMD_V_ONCE] || cmd[`HMCP_CMD_I_ONCE];
  assign cmdWrite     = (state == HMCP_WRITE) && byteEnd && (byteIdx == 2'h0)
                        && !rxShift[`HMCP_CMD_EXT];
  assign extAddrWrite = (state == HMCP_WRITE) && byteEnd && (byteIdx == 2'h0)
                        && rxShift[`HMCP_CMD_EXT];
  assign extDataWrite = (state == HMCP_WRITE) && byteEnd && (byteIdx == 2'h1)
                        && extPending;
  assign sdaOut = 1'b0;

  // Readback byte selection
  function automatic logic [7:0] readByte(input logic [1:0] idx);
    logic [7:0] b;
    b = 8'h00;
    if (cmd[`HMCP_CMD_STAT_SEL]) begin
      b = statusIn;
    end else if (voltSel && currSel) begin
      case (idx)
        2'h0:    b = voltResult[11:4];
        2'h1:    b = currResult[11:4];
        2'h2:    b = {voltResult[3:0], currResult[3:0]};
        default: b = 8'h00;
      endcase
    end else if (voltSel || currSel) begin
      case (idx)
        2'h0:    b = voltSel ? voltResult[11:4] : currResult[11:4];
        2'h1:    b = {voltSel ? voltResult[3:0] : currResult[3:0], 4'h0};
        default: b = 8'h00;
      endcase
    end
    return b;
  endfunction : readByte

  always_comb begin
    firstByte  = readByte(2'h0);
    followByte = readByte(byteIdx + 2'h1);
  end

  // ---------------------------------------------------------------
  // Bus state machine
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= HMCP_IDLE;
      bitCnt     <= 4'h0;
      rxShift    <= 8'h00;
      txShift    <= 8'h00;
      byteIdx    <= 2'h0;
      extPending <= 1'b0;
      sdaOe      <= 1'b0;
    end else if (startSeen) begin
      state      <= HMCP_ADDR;
      bitCnt     <= 4'h0;
      byteIdx    <= 2'h0;
      extPending <= 1'b0;
      sdaOe      <= 1'b0;
    end else if (stopSeen) begin
      state <= HMCP_IDLE;
      sdaOe <= 1'b0;
    end else begin
      case (state)
        HMCP_ADDR, HMCP_WRITE: begin
          if (sclRise && bitCnt != `HMCP_BYTE_BITS) begin
            rxShift <= {rxShift[6:0], sdaQ2};
            bitCnt  <= bitCnt + 4'h1;
          end else if (byteEnd && state == HMCP_ADDR) begin
            if (addrMatch && !(rxShift[0] && onceBusy)) begin
              state <= HMCP_ADDR_ACK;
              sdaOe <= 1'b1;
            end else begin
              state <= HMCP_IGNORE;
            end
          end else if (byteEnd) begin
            state <= HMCP_WRITE_ACK;
            sdaOe <= 1'b1;
            if (byteIdx != 2'h3) begin
              byteIdx <= byteIdx + 2'h1;
            end
            if (extAddrWrite) begin
              extPending <= 1'b1;
            end
          end
        end
        HMCP_ADDR_ACK: begin
          if (sclFall) begin
            bitCnt <= 4'h0;
            if (rxShift[0]) begin
              state   <= HMCP_READ;
              txShift <= firstByte;
              sdaOe   <= !firstByte[7];
              bitCnt  <= 4'h1;
            end else begin
              state <= HMCP_WRITE;
              sdaOe <= 1'b0;
            end
          end
        end
        HMCP_WRITE_ACK: begin
          if (sclFall) begin
            state  <= HMCP_WRITE;
            sdaOe  <= 1'b0;
            bitCnt <= 4'h0;
          end
        end
        HMCP_READ: begin
          if (byteEnd) begin
            state <= HMCP_READ_ACK;
            sdaOe <= 1'b0;
          end else if (sclFall) begin
            sdaOe   <= !txShift[6];
            txShift <= {txShift[6:0], 1'b0};
            bitCnt  <= bitCnt + 4'h1;
          end
        end
        HMCP_READ_ACK: begin
          if (sclRise && sdaQ2) begin
            state <= HMCP_IGNORE;
          end else if (sclFall) begin
            state   <= HMCP_READ;
            byteIdx <= byteIdx + 2'h1;
            txShift <= followByte;
            sdaOe   <= !followByte[7];
            bitCnt  <= 4'h1;
          end
        end
        HMCP_IGNORE: begin
          sdaOe <= 1'b0;
        end
        default: begin
          state <= HMCP_IDLE;
          sdaOe <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Command byte and extended writes
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd     <= `HMCP_CMD_RESET;
      voltSel <= 1'b0;
      currSel <= 1'b0;
    end else if (cmdWrite) begin
      cmd <= rxShift & ~(8'h01 << `HMCP_CMD_UNUSED);
      voltSel <= rxShift[`HMCP_CMD_VOLTAGE_CONTINUOUS] || rxShift[`HMCP_CMD_V_ONCE];
      currSel <= rxShift[`HMCP_CMD_CURRENT_CONTINUOUS] || rxShift[`HMCP_CMD_I_ONCE];
    end else if (convStore && convChannel == HMCP_CHAN_VOLT) begin
      cmd[`HMCP_CMD_V_ONCE] <= 1'b0;
    end else if (convStore) begin
      cmd[`HMCP_CMD_I_ONCE] <= 1'b0;
    end
  end

  assign dividerSelect = cmd[`HMCP_CMD_DIV_SEL];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      extRegAddr  <= 2'h0;
      extRegData  <= 8'h00;
      extRegWrite <= 1'b0;
    end else begin
      extRegWrite <= extDataWrite;
      if (extAddrWrite) begin
        extRegAddr <= rxShift[1:0];
      end
      if (extDataWrite) begin
        extRegData <= rxShift;
      end
    end
  end

  // ---------------------------------------------------------------
  // Conversion scheduling
  // ---------------------------------------------------------------
  assign voltReq   = cmd[`HMCP_CMD_VOLTAGE_CONTINUOUS] || cmd[`HMCP_CMD_V_ONCE];
  assign currReq   = cmd[`HMCP_CMD_CURRENT_CONTINUOUS] || cmd[`HMCP_CMD_I_ONCE];
  assign convStore = adcBusy && convDone;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      adcBusy     <= 1'b0;
      convStart   <= 1'b0;
      convChannel <= HMCP_CHAN_VOLT;
      lastChan    <= HMCP_CHAN_CURR;
    end else begin
      convStart <= 1'b0;
      if (convStore) begin
        adcBusy  <= 1'b0;
        lastChan <= convChannel;
      end else if (!adcBusy && (voltReq || currReq)) begin
        adcBusy   <= 1'b1;
        convStart <= 1'b1;
        if (currReq && (!voltReq || lastChan == HMCP_CHAN_VOLT)) begin
          convChannel <= HMCP_CHAN_CURR;
        end else begin
          convChannel <= HMCP_CHAN_VOLT;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      voltResult <= `HMCP_RESULT_RESET;
      currResult <= `HMCP_RESULT_RESET;
    end else if (cmdWrite) begin
      voltResult <= `HMCP_RESULT_RESET;
      currResult <= `HMCP_RESULT_RESET;
    end else if (convStore && convChannel == HMCP_CHAN_VOLT) begin
      voltResult <= convData;
    end else if (convStore) begin
      currResult <= convData;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  addr_ack_low_a: assert property (
    (state == HMCP_ADDR && byteEnd && addrMatch && !rxShift[0]) |=> sdaOe [*1]
  ) else $error("Matched address not acknowledged");
  mismatch_quiet_a: assert property ((state == HMCP_IGNORE) |-> !sdaOe)
    else $error("SDA driven while ignoring transfer");
  sda_scl_low_a: assert property ($changed(sdaOe) |-> !sclQ2)
    else $error("SDA changed while SCL high");
  start_to_addr_a: assert property (
    startSeen |=> (state == HMCP_ADDR && bitCnt == 4'h0)
  ) else $error("Start not followed by address phase");
  once_clear_a: assert property (
    (convStore && convChannel == HMCP_CHAN_VOLT && !cmdWrite)
      |=> !cmd[`HMCP_CMD_V_ONCE]
  ) else $error("Single voltage bit did not clear");
  read_once_nack_a: assert property ((state == HMCP_READ) |-> !onceBusy)
    else $error("Read served during single conversion");
  cmd_stable_a: assert property ((!cmdWrite && !convStore) |=> $stable(cmd))
    else $error("Command changed without a command write");
  early_zero_a: assert property (
    cmdWrite |=> (voltResult == 12'h000 && currResult == 12'h000)
  ) else $error("Results not cleared on command write");
  divider_sel_a: assert property (
    cmdWrite |=> dividerSelect == $past(rxShift[`HMCP_CMD_DIV_SEL])
  ) else $error("Divider select not taken from command");
  unused_bit_a: assert property (!cmd[`HMCP_CMD_UNUSED] && !cmd[`HMCP_CMD_EXT])
    else $error("Unused command bit set");
  conv_start_a: assert property (convStart |-> adcBusy ##1 !convStart)
    else $error("Conversion start malformed");

endmodule : hmcp_i2c_port

`default_nettype wire

// >>> hmcp_i2c_master.sv
/*
  Bus master model for the monitor command port: start, stop, byte
  write and byte read with acknowledge, stepped on ref_clk.
  Assumes the bench resolves the SDA wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module hmcp_i2c_master (
  input  wire logic       clk,
  input  wire logic       sdaWire,
  output logic            scl,
  output logic            sdaDrv,
  output logic            rxStb,
  output logic            rxAck,
  output logic [7:0]      rxData
);
  int lowExtra = 0;
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
    rxStb = 1'b0;
    rxAck = 1'b0;
    rxData = 8'h00;
  end
  // ----------------------------------------
  // Bus steps
  // ----------------------------------------
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task bitx(input logic b, output logic r);
    cyc(1);
    sdaDrv <= b;
    cyc(5 + lowExtra);
    scl <= 1'b1;
    cyc(3);
    r = sdaWire;
    cyc(3);
    scl <= 1'b0;
  endtask : bitx
  task start();
    sdaDrv <= 1'b1;
    scl <= 1'b1;
    cyc(6);
    sdaDrv <= 1'b0;
    cyc(6);
    scl <= 1'b0;
  endtask : start
  task stop();
    cyc(1);
    sdaDrv <= 1'b0;
    cyc(5);
    scl <= 1'b1;
    cyc(6);
    sdaDrv <= 1'b1;
    cyc(6);
  endtask : stop
  task note(input logic a, input logic [7:0] d);
    rxAck <= a;
    rxData <= d;
    rxStb <= 1'b1;
    cyc(1);
    rxStb <= 1'b0;
  endtask : note
  task wbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    note(~r, d);
  endtask : wbyte
  task rbyte(input logic ackIt);
    logic r;
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(~ackIt, r);
    note(ackIt, d);
  endtask : rbyte
endmodule : hmcp_i2c_master
`default_nettype wire

// >>> hmcp_i2c_port_test.sv
/*
  Self-checking bench of the monitor command port: master model on the
  link, converter model and byte checker on ref_clk.
  Assumes the port, its package, header and the master model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module hmcp_i2c_port_test
  import hmcp_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        reset_n;
  logic [1:0]  addrStrap;
  logic        convDone;
  logic [11:0] convData;
  logic [7:0]  statusIn;
  logic        sdaOut, sdaOe, convStart, dividerSelect, extRegWrite;
  hmcp_chan_t  convChannel;
  logic [1:0]  extRegAddr;
  logic [7:0]  extRegData, rxData;
  logic        scl, sdaDrv, rxStb, rxAck;
  wire logic   sdaWire;
  int          seed = 20;
  int          r, convLat = 20, busyCnt = 0, doneCnt = 0, bad_count = 0, n_checks = 0;
  logic [11:0] vVal, iVal;
  logic [6:0]  myAddr;
  logic [8:0]  expQ[$];
  logic [9:0]  extQ[$];
  always #2 ref_clk = ~ref_clk;
  assign sdaWire = sdaDrv & ~(sdaOe & ~sdaOut);
  hmcp_i2c_port dut (.ref_clk(ref_clk), .reset_n(reset_n), .sclIn(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrap(addrStrap), .convStart(convStart),
    .convChannel(convChannel), .convDone(convDone), .convData(convData),
    .dividerSelect(dividerSelect), .statusIn(statusIn), .extRegAddr(extRegAddr),
    .extRegData(extRegData), .extRegWrite(extRegWrite));
  hmcp_i2c_master m (.clk(ref_clk), .sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv),
    .rxStb(rxStb), .rxAck(rxAck), .rxData(rxData));
  // ----------------------------------------
  // Converter model and checker
  // ----------------------------------------
  always @(posedge ref_clk) begin
    convDone <= (busyCnt == 1);
    if (busyCnt == 1) begin
      convData <= (convChannel == HMCP_CHAN_CURR) ? iVal : vVal;
      doneCnt <= doneCnt + 1;
    end else if (reset_n !== 1'b1) begin
      convData <= 12'h000;
    end
    if (convStart === 1'b1) busyCnt <= convLat;
    else if (busyCnt != 0) busyCnt <= busyCnt - 1;
  end
  task fail(input string msg);
    bad_count++;
    $display("ERROR at %0t: %s", $time, msg);
  endtask : fail
  always @(posedge ref_clk) begin
    if (rxStb === 1'b1) begin
      n_checks++;
      if (expQ.size() == 0) fail("unexpected byte");
      else if ({rxAck, rxData} !== expQ.pop_front()) fail("byte or ack differs");
    end
    if (extRegWrite === 1'b1) begin
      n_checks++;
      if (extQ.size() == 0) fail("unexpected extended write");
      else if ({extRegAddr, extRegData} !== extQ.pop_front()) fail("ext differs");
    end
  end
  task report_and_stop();
    if (expQ.size() != 0 || extQ.size() != 0) fail("expected results left over");
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail("run too long");
    report_and_stop();
  end
  // ----------------------------------------
  // Transfers
  // ----------------------------------------
  task note(input logic a, input logic [7:0] d);
    expQ.push_back({a, d});
  endtask : note
  task quick(input logic [6:0] a, input logic hit);
    m.start();
    note(hit, {a, 1'b0});
    m.wbyte({a, 1'b0});
    if (!hit) begin
      note(1'b0, 8'h55);
      m.wbyte(8'h55);
    end
    m.stop();
    m.cyc(6);
  endtask : quick
  task wr(input int n, input logic [7:0] b0, input logic [7:0] b1);
    m.start();
    note(1'b1, {myAddr, 1'b0});
    m.wbyte({myAddr, 1'b0});
    note(1'b1, b0);
    m.wbyte(b0);
    if (n > 1) begin
      note(1'b1, b1);
      m.wbyte(b1);
    end
    m.stop();
    m.cyc(6);
  endtask : wr
  task rd(input int n, input logic [23:0] e);
    m.start();
    note(n != 0, {myAddr, 1'b1});
    m.wbyte({myAddr, 1'b1});
    for (int k = 0; k < n; k++) begin
      note(k != n - 1, e[23 - 8 * k -: 8]);
      m.rbyte(k != n - 1);
    end
    m.stop();
    m.cyc(6);
  endtask : rd
  task waitDone(input int n);
    int t0;
    t0 = doneCnt;
    for (int k = 0; k < 5000 && doneCnt < t0 + n; k++) @(posedge ref_clk);
    if (doneCnt < t0 + n) begin
      fail("converter wait ran out");
      report_and_stop();
    end
    m.cyc(4);
  endtask : waitDone
  task checkDiv(input logic v);
    n_checks++;
    if (dividerSelect !== v) fail("divider select differs");
  endtask : checkDiv
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    reset_n <= 1'b0;
    addrStrap <= 2'h0;
    r = $random(seed);
    vVal = r[11:0];
    r = $random(seed);
    iVal = r[11:0];
    r = $random(seed);
    statusIn <= r[7:0];
    @(posedge ref_clk);
    for (int s = 0; s < 4; s++) begin
      addrStrap <= s[1:0];
      reset_n <= 1'b0;
      m.cyc(16);
      reset_n <= 1'b1;
      m.cyc(8);
      myAddr = {5'h16, s[1:0]};
      checkDiv(1'b0);
      quick(myAddr ^ 7'h01, 1'b0);
      quick(myAddr, 1'b1);
    end
    $display("test address done");
    convLat = 300;
    wr(1, 8'h02, 8'h00);
    rd(0, 24'h000000);
    waitDone(1);
    rd(2, {vVal, 12'h000});
    wr(1, 8'h08, 8'h00);
    rd(0, 24'h000000);
    waitDone(1);
    rd(2, {iVal, 12'h000});
    $display("test single done");
    m.lowExtra = 20;
    wr(1, 8'h40, 8'h00);
    rd(1, {statusIn, 16'h0000});
    m.lowExtra = 0;
    r = $random(seed);
    extQ.push_back({2'h2, r[7:0]});
    wr(2, 8'h82, r[7:0]);
    $display("test status and extended done");
    convLat = 1000;
    wr(1, 8'h11, 8'h00);
    checkDiv(1'b1);
    rd(2, 24'h000000);
    convLat = 20;
    waitDone(1);
    rd(2, {vVal, 12'h000});
    quick(myAddr, 1'b1);
    checkDiv(1'b1);
    rd(2, {vVal, 12'h000});
    $display("test continuous voltage done");
    wr(1, 8'h05, 8'h00);
    checkDiv(1'b0);
    waitDone(3);
    rd(3, {vVal[11:4], iVal[11:4], vVal[3:0], iVal[3:0]});
    $display("test both quantities done");
    m.cyc(20);
    report_and_stop();
  end
endmodule : hmcp_i2c_port_test
`default_nettype wire
